// ---- hdl/lane_select_consts.svh ----
// constants for the external bus byte lane select block
`ifndef LANE_SELECT_CONSTS_SVH
`define LANE_SELECT_CONSTS_SVH
`define CFG_POLARITY_BIT 15
`define LANE_LOW_BIT 0
`define LANE_HIGH_BIT 1
`define LANES_NONE 2'h0
`define LANES_BOTH 2'h3
`define LANES_LOW 2'h1
`define LANES_HIGH 2'h2
`endif

// ---- hdl/lane_select_pkg.sv ----
// types shared by the byte lane select block
package lane_select_pkg;
    // transfer size requested by the bus interface unit
    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_HALF = 2'h1
    } xfer_size_t;
    // access phase state, one-hot
    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_ACCESS = 2'b10
    } lane_state_t;
endpackage : lane_select_pkg

// ---- hdl/lane_polarity.sv ----
// applies the programmable sense to the active-high lane selects
`timescale 1ns/1ps
`include "lane_select_consts.svh"
module lane_polarity (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic activeHigh,
    input wire logic [1:0] laneActive,
    output logic [1:0] byteLaneSelect
);
    // ----------------------------------------
    // output stage
    // ----------------------------------------
    // pin value before the flop; invert when active low
    wire [1:0] pinNxt = activeHigh ? laneActive : ~laneActive;
    logic [1:0] pin_r; // registered pins, glitch free
    // reset shows both lanes negated in the default low sense
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pin_r <= ~`LANES_NONE;
        end else begin
            pin_r <= pinNxt;
        end
    end
    assign byteLaneSelect = pin_r;
endmodule : lane_polarity

// ---- hdl/external_bus_byte_lane_select.sv ----
// byte lane select generation for the external 16-bit data bus
`timescale 1ns/1ps
`include "lane_select_consts.svh"
module external_bus_byte_lane_select (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic [15:0] busCfg,
    input wire logic xferStart,
    input wire logic xferEnd,
    input wire lane_select_pkg::xfer_size_t xferSize,
    input wire logic addrLsb,
    output logic [1:0] byteLaneSelect,
    output logic lowLaneSelect,
    output logic highLaneSelect,
    output logic xferBusy
);
    import lane_select_pkg::*;

    // ----------------------------------------
    // lane decode
    // ----------------------------------------
    // picks the lanes carrying data for a transfer
    function automatic logic [1:0] lanes_for(input xfer_size_t sz, input logic lsb);
        logic [1:0] l;
        l = `LANES_NONE;
        if (sz == SIZE_HALF) begin
            l = `LANES_BOTH;
        end else begin
            l[`LANE_LOW_BIT] = ~lsb;
            l[`LANE_HIGH_BIT] = lsb;
        end
        return l;
    endfunction : lanes_for

    // ----------------------------------------
    // access tracking
    // ----------------------------------------
    lane_state_t state_r; // access phase
    lane_state_t state_nxt; // next phase
    logic [1:0] lanes_r; // lanes held for the access
    wire [1:0] lanesStart = lanes_for(xferSize, addrLsb); // decode of new request
    wire activeHigh = busCfg[`CFG_POLARITY_BIT];

    // next phase; a new start wins over an end in the same cycle
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            ST_IDLE: begin
                if (xferStart) begin
                    state_nxt = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (xferEnd && !xferStart) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // state and latched lanes; a single-byte write leaves the other lane negated
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= ST_IDLE;
            lanes_r <= `LANES_NONE;
        end else begin
            state_r <= state_nxt;
            if (xferStart) begin
                lanes_r <= lanesStart;
            end else if (xferEnd) begin
                lanes_r <= `LANES_NONE;
            end
        end
    end

    // ----------------------------------------
    // pins
    // ----------------------------------------
    lane_polarity u_pol (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .activeHigh(activeHigh),
        .laneActive(lanes_r),
        .byteLaneSelect(byteLaneSelect)
    );
    assign lowLaneSelect = byteLaneSelect[`LANE_LOW_BIT];
    assign highLaneSelect = byteLaneSelect[`LANE_HIGH_BIT];
    assign xferBusy = (state_r == ST_ACCESS);

    // ----------------------------------------
    // checks
    // ----------------------------------------
    // the pin checks ask for one settle cycle with no new start and no end,
    // though the pins take the latched lanes on the same edge that either would replace them

    // half word, active-high sense: both pins high
    property p_half_both;
        @(posedge clk_sys) disable iff (!arst_n)
        (xferStart && xferSize == SIZE_HALF && activeHigh)
            ##1 (activeHigh && !xferStart && !xferEnd)
            |=> byteLaneSelect == `LANES_BOTH;
    endproperty
    a_half_both: assert property (p_half_both)
        else $error("half word must assert both lanes");

    // half word, active-low sense: both pins low
    property p_half_both_low;
        @(posedge clk_sys) disable iff (!arst_n)
        (xferStart && xferSize == SIZE_HALF && !activeHigh)
            ##1 (!activeHigh && !xferStart && !xferEnd)
            |=> byteLaneSelect == `LANES_NONE;
    endproperty
    a_half_both_low: assert property (p_half_both_low)
        else $error("half word must assert both lanes low");

    // low byte, active-low sense: only the low pin pulled low
    property p_low_byte;
        @(posedge clk_sys) disable iff (!arst_n)
        (xferStart && xferSize == SIZE_BYTE && !addrLsb)
            ##1 (!activeHigh && !xferStart && !xferEnd)
            |=> byteLaneSelect == (~`LANES_LOW);
    endproperty
    a_low_byte: assert property (p_low_byte)
        else $error("low byte lane wrong");

    // high byte, active-low sense: only the high pin pulled low
    property p_high_byte;
        @(posedge clk_sys) disable iff (!arst_n)
        (xferStart && xferSize == SIZE_BYTE && addrLsb)
            ##1 (!activeHigh && !xferStart && !xferEnd)
            |=> byteLaneSelect == (~`LANES_HIGH);
    endproperty
    a_high_byte: assert property (p_high_byte)
        else $error("high byte lane wrong");

    // low byte, active-high sense
    property p_low_byte_hi;
        @(posedge clk_sys) disable iff (!arst_n)
        (xferStart && xferSize == SIZE_BYTE && !addrLsb)
            ##1 (activeHigh && !xferStart && !xferEnd)
            |=> byteLaneSelect == `LANES_LOW;
    endproperty
    a_low_byte_hi: assert property (p_low_byte_hi)
        else $error("low byte lane wrong in high sense");

    // high byte, active-high sense
    property p_high_byte_hi;
        @(posedge clk_sys) disable iff (!arst_n)
        (xferStart && xferSize == SIZE_BYTE && addrLsb)
            ##1 (activeHigh && !xferStart && !xferEnd)
            |=> byteLaneSelect == `LANES_HIGH;
    endproperty
    a_high_byte_hi: assert property (p_high_byte_hi)
        else $error("high byte lane wrong in high sense");

    // a byte access never shows both halves selected
    property p_one_lane;
        @(posedge clk_sys) disable iff (!arst_n)
        (xferStart && xferSize == SIZE_BYTE) ##1 (!xferStart && !xferEnd)
            |=> (lowLaneSelect != highLaneSelect);
    endproperty
    a_one_lane: assert property (p_one_lane)
        else $error("byte write drove both lanes");

    // quiet bus keeps both pins negated in the current sense
    property p_idle_neg;
        @(posedge clk_sys) disable iff (!arst_n)
        (state_r == ST_IDLE && !xferStart && !$past(xferStart))
            |=> byteLaneSelect == {2{~$past(activeHigh)}};
    endproperty
    a_idle_neg: assert property (p_idle_neg)
        else $error("idle lanes not negated");

    // pins follow the held lanes through the programmed sense
    property p_polarity;
        @(posedge clk_sys) disable iff (!arst_n)
        1'b1 |=> byteLaneSelect == ($past(activeHigh) ? $past(lanes_r) : ~$past(lanes_r));
    endproperty
    a_polarity: assert property (p_polarity)
        else $error("lane polarity wrong");

    // a start always opens an access
    property p_start_busy;
        @(posedge clk_sys) disable iff (!arst_n)
        xferStart |=> xferBusy;
    endproperty
    a_start_busy: assert property (p_start_busy)
        else $error("start did not open an access");

    // a lone end closes the access
    property p_end_idle;
        @(posedge clk_sys) disable iff (!arst_n)
        (xferBusy && xferEnd && !xferStart) |=> !xferBusy;
    endproperty
    a_end_idle: assert property (p_end_idle)
        else $error("end did not close the access");

    // start and end together: the start wins
    property p_start_wins;
        @(posedge clk_sys) disable iff (!arst_n)
        (xferStart && xferEnd) |=> xferBusy;
    endproperty
    a_start_wins: assert property (p_start_wins)
        else $error("end beat a start in the same cycle");

    // after a lone end both pins go back to negated
    property p_end_negate;
        @(posedge clk_sys) disable iff (!arst_n)
        (xferBusy && xferEnd && !xferStart) ##1 !xferStart
            |=> byteLaneSelect == {2{~$past(activeHigh)}};
    endproperty
    a_end_negate: assert property (p_end_negate)
        else $error("lanes not negated after end");

    // lanes stay put while an access runs undisturbed
    property p_hold;
        @(posedge clk_sys) disable iff (!arst_n)
        (xferBusy && !xferStart && !xferEnd) |=> lanes_r == $past(lanes_r);
    endproperty
    a_hold: assert property (p_hold)
        else $error("lanes changed inside an access");

    // every start, back to back too, takes the lanes of the new request
    property p_new_lanes;
        @(posedge clk_sys) disable iff (!arst_n)
        xferStart |=> lanes_r == $past(lanesStart);
    endproperty
    a_new_lanes: assert property (p_new_lanes)
        else $error("start did not load its lanes");
endmodule : external_bus_byte_lane_select

// ---- verif/lane_periph.sv ----
// model of a 16-bit peripheral register with per-byte write lanes
`timescale 1ns/1ps
module lane_periph (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic activeHigh,
    input wire logic wrEn,
    input wire logic [15:0] dataBus,
    input wire logic [1:0] byteLaneSelect,
    output logic [15:0] regVal
);
    // lane on/off after the programmed sense is undone
    wire logic [1:0] laneOn = activeHigh ? byteLaneSelect : ~byteLaneSelect;
    // each half is written only while its lane is on, so byte writes can split a word
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            regVal <= 16'h0000;
        end else if (wrEn) begin
            if (laneOn[0]) regVal[7:0] <= dataBus[7:0];
            if (laneOn[1]) regVal[15:8] <= dataBus[15:8];
        end
    end
endmodule : lane_periph

// ---- verif/external_bus_byte_lane_select_tb.sv ----
// self-checking bench for the byte lane select block
`timescale 1ns/1ps
module external_bus_byte_lane_select_tb;
    import lane_select_pkg::*;
    logic clk_sys = 0, arst_n = 0, xferStart = 0, xferEnd = 0, addrLsb = 0, wrEn = 0;
    logic [15:0] busCfg = 16'h0000, dataBus = 16'h0000, expReg = 16'h0000, regVal;
    xfer_size_t xferSize = SIZE_BYTE;
    logic [1:0] byteLaneSelect;
    logic lowLaneSelect, highLaneSelect, xferBusy;
    int fail_count = 0, checked = 0;
    external_bus_byte_lane_select u_external_bus_byte_lane_select (.clk_sys(clk_sys),
        .arst_n(arst_n), .busCfg(busCfg), .xferStart(xferStart), .xferEnd(xferEnd),
        .xferSize(xferSize), .addrLsb(addrLsb), .byteLaneSelect(byteLaneSelect),
        .lowLaneSelect(lowLaneSelect), .highLaneSelect(highLaneSelect), .xferBusy(xferBusy));
    lane_periph u_lane_periph (.clk_sys(clk_sys), .arst_n(arst_n), .activeHigh(busCfg[15]),
        .wrEn(wrEn), .dataBus(dataBus), .byteLaneSelect(byteLaneSelect), .regVal(regVal));
    // ----------------------------------------
    // clock, helpers
    // ----------------------------------------
    initial forever #25 clk_sys = ~clk_sys;
    task chk(input string what, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task close_out;
        if (fail_count == 0 && checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out
    // one access; pins show two edges after the start edge, idle two after the end edge
    task xfer(input xfer_size_t s, input logic l, input logic [15:0] d);
        logic [1:0] lanes, on;
        lanes = (s == SIZE_HALF) ? 2'b11 : (l ? 2'b10 : 2'b01);
        on = busCfg[15] ? lanes : ~lanes;
        @(posedge clk_sys) xferStart <= 1'b1;
        xferSize <= s;
        addrLsb <= l;
        @(posedge clk_sys) xferStart <= 0;
        repeat (2) @(posedge clk_sys);
        #1 chk("sel", 16'(byteLaneSelect), 16'(on));
        chk("copies", 16'({highLaneSelect, lowLaneSelect}), 16'(on));
        chk("busy", 16'(xferBusy), 16'h0001);
        @(posedge clk_sys) {wrEn, xferEnd, dataBus} <= {2'b11, d};
        @(posedge clk_sys) {wrEn, xferEnd} <= 2'b00;
        if (lanes[0]) expReg[7:0] = d[7:0];
        if (lanes[1]) expReg[15:8] = d[15:8];
        repeat (2) @(posedge clk_sys);
        #1 chk("idle", 16'(byteLaneSelect), busCfg[15] ? 16'h0000 : 16'h0003);
        chk("busy low", 16'(xferBusy), 16'h0000);
        chk("reg", regVal, expReg);
    endtask : xfer
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // active-low sense, word built from two byte writes
    task t_low_sense;
        xfer(SIZE_BYTE, 1'b0, 16'hA1B2);
        xfer(SIZE_BYTE, 1'b1, 16'hC3D4);
        xfer(SIZE_HALF, 1'b0, 16'h1357);
    endtask : t_low_sense
    // active-high sense, half word then a high byte and a low byte
    task t_high_sense;
        @(posedge clk_sys) busCfg <= 16'h8000;
        repeat (2) @(posedge clk_sys);
        #1 chk("flip", 16'(byteLaneSelect), 16'h0000);
        xfer(SIZE_HALF, 1'b0, 16'h5E6F);
        xfer(SIZE_BYTE, 1'b1, 16'h7788);
        xfer(SIZE_BYTE, 1'b0, 16'h9AB0);
    endtask : t_high_sense
    // start on top of an end, high sense: the start wins, its lanes replace the old
    task t_collide;
        @(posedge clk_sys) xferStart <= 1'b1;
        xferSize <= SIZE_BYTE;
        addrLsb <= 1'b0;
        @(posedge clk_sys) xferEnd <= 1'b1;
        addrLsb <= 1'b1;
        @(posedge clk_sys) xferStart <= 1'b0;
        xferEnd <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk("won", 16'(byteLaneSelect), 16'h0002);
        chk("kept", 16'(xferBusy), 16'h0001);
        @(posedge clk_sys) xferEnd <= 1'b1;
        @(posedge clk_sys) xferEnd <= 1'b0;
        repeat (2) @(posedge clk_sys);
        #1 chk("shut", 16'(byteLaneSelect), 16'h0000);
        chk("done", 16'(xferBusy), 16'h0000);
    endtask : t_collide
    initial begin
        repeat (4) @(posedge clk_sys);
        chk("rst", 16'({xferBusy, byteLaneSelect}), 16'h0003);
        arst_n <= 1;
        t_low_sense();
        t_high_sense();
        t_collide();
        close_out();
    end
    // watchdog, about six times the expected run
    initial begin
        #20000;
        fail_count++;
        close_out();
    end
endmodule : external_bus_byte_lane_select_tb
